// [dv/rtd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rtd_host_model (
  // clock and request from the bench
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [3:0] gap_in,
  // command traffic toward the device
  output logic host_cmd_out,
  output logic host_resp_sent_out
);
  // one command pulse, a reply gap, then the reply-sent pulse
  initial
  begin
    host_cmd_out = 1'b0;
    host_resp_sent_out = 1'b0;
    forever
    begin
      @(posedge clk_in);
      if (go_in)
      begin
        @(negedge clk_in);
        host_cmd_out = 1'b1;
        @(negedge clk_in);
        host_cmd_out = 1'b0;
        repeat (gap_in) @(negedge clk_in);
        host_resp_sent_out = 1'b1;
        @(negedge clk_in);
        host_resp_sent_out = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/rtd_regmap_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module rtd_regmap_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic reg_err_out,
  // events and outputs
  input wire logic host_cmd_in,
  input wire logic host_resp_sent_in,
  input wire logic output_write_cmd_in,
  input wire logic protocol_rtu_out,
  input wire logic filter_50hz_out,
  input wire logic [7:0] comm_addr_out,
  input wire logic [7:0] comm_speed_out,
  input wire logic recovery_out,
  input wire logic wd_timeout_out,
  input wire logic power_indicator_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic first_q;
  wire logic rd_first = reg_rd_in && reg_addr_in == rtd_pkg::A_FIRST_RD;
  // power-up read seen
  always_ff @(posedge clk_in)
  begin
    if (reset_in) first_q <= 1'b0;
    else if (rd_first) first_q <= 1'b1;
  end
  property p_ack; (reg_rd_in || reg_wr_in) |=> reg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_noack; !(reg_rd_in || reg_wr_in) |=> !reg_ack_out; endproperty
  a_noack: assert property (p_noack) else $error("stray ack");
  property p_err; reg_err_out |-> reg_ack_out; endproperty
  a_err: assert property (p_err) else $error("err without ack");
  property p_frst; rd_first && !first_q |=> reg_rdata_out == 16'h0001;
  endproperty
  a_frst: assert property (p_frst) else $error("first read");
  property p_later; rd_first && first_q |=> reg_rdata_out == 16'h0000;
  endproperty
  a_later: assert property (p_later) else $error("later read");
  property p_dark; host_cmd_in |=> !power_indicator_out; endproperty
  a_dark: assert property (p_dark) else $error("led on");
  property p_lit; host_resp_sent_in && !host_cmd_in |=> power_indicator_out;
  endproperty
  a_lit: assert property (p_lit) else $error("led off");
  property p_recov; recovery_out |-> comm_addr_out == 8'h00 &&
    comm_speed_out == 8'h06 && !protocol_rtu_out; endproperty
  a_recov: assert property (p_recov) else $error("recovery link");
  property p_filt; reg_wr_in && reg_addr_in == rtd_pkg::A_FILTER |=>
    filter_50hz_out == $past(reg_wdata_in[0]); endproperty
  a_filt: assert property (p_filt) else $error("filter");
  property p_proto; reg_wr_in && reg_addr_in == rtd_pkg::A_PROTOCOL &&
    !recovery_out |=> protocol_rtu_out == $past(reg_wdata_in[0]); endproperty
  a_proto: assert property (p_proto) else $error("protocol");
  property p_wdclr; $fell(wd_timeout_out) |->
    $past(reg_wr_in) || $past(output_write_cmd_in); endproperty
  a_wdclr: assert property (p_wdclr) else $error("flag lost");
endmodule
bind rtd_regmap rtd_regmap_monitor rtd_regmap_monitor_inst (.*);
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'b0, reset_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000, reg_wdata_in = 16'h0000,
    meas_hex_in = 16'h0000;
  logic output_write_cmd_in = 1'b0, sample_valid_in = 1'b0, go = 1'b0;
  logic signed [31:0] meas_eng_in = 32'h0;
  logic [31:0] resistance_in = 32'h0;
  logic recovery_in = 1'b0, digital_input_line_in = 1'b0;
  wire logic host_cmd_in;
  wire logic host_resp_sent_in;
  logic [15:0] reg_rdata_out, reply_delay_out, display_indicator_out;
  logic [7:0] comm_addr_out, comm_speed_out;
  logic reg_ack_out, reg_err_out, protocol_rtu_out, filter_50hz_out;
  logic recovery_out, digital_output_out, alarm_out, wd_timeout_out;
  logic power_indicator_out, display_host_out;
  int mismatches = 0, total_checks = 0, cycles = 0, seed = 95;
  logic [17:0] expq [$];
  logic [17:0] e;
  logic [7:0] codes [15] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2E, 8'h2F, 8'h80, 8'h81};
  int lo [15] = '{-10000, 0, 0, 0, -10000, 0, 0, 0, -8000, 0, -2000,
    -20000, -20000, -2000, -2000};
  int hi [15] = '{10000, 10000, 20000, 6000, 10000, 10000, 20000, 6000,
    10000, 10000, 6000, 20000, 20000, 6000, 6000};
  rtd_regmap #(.TICK_CYCLES(10)) rtd_regmap_inst (.*);
  rtd_host_model rtd_host_model_inst (.clk_in, .go_in(go), .gap_in(4'h3),
    .host_cmd_out(host_cmd_in), .host_resp_sent_out(host_resp_sent_in));
  always #25 clk_in = ~clk_in;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [16:0] s, input logic [16:0] x);
    total_checks++;
    if (s !== x)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  // one access, expectation queued
  task automatic acc(input logic w, input logic [15:0] a,
      input logic [15:0] d, input logic [17:0] x);
    @(negedge clk_in);
    expq.push_back(x);
    reg_wr_in = w;
    reg_rd_in = ~w;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, a, d, 18'h0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [16:0] x);
    acc(1'b0, a, 16'h0, {1'b1, x});
  endtask
  task automatic smp(input int v);
    @(negedge clk_in);
    sample_valid_in = 1'b1;
    meas_eng_in = v;
    meas_hex_in = $random(seed);
    resistance_in = $random(seed);
    @(negedge clk_in);
    sample_valid_in = 1'b0;
  endtask
  // host command via the partner
  task automatic cmd();
    @(negedge clk_in);
    go = 1'b1;
    @(negedge clk_in);
    go = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(power_indicator_out, 1'b0);
    repeat (4) @(negedge clk_in);
    chk(power_indicator_out, 1'b1);
  endtask
  task automatic pulse_out_cmd();
    @(negedge clk_in);
    output_write_cmd_in = 1'b1;
    @(negedge clk_in);
    output_write_cmd_in = 1'b0;
    @(negedge clk_in);
  endtask
  // matches each acknowledge with the oldest note
  always @(negedge clk_in)
  begin
    if (reg_ack_out === 1'b1)
    begin
      e = expq.pop_front();
      if (e[17]) chk({reg_err_out, reg_rdata_out}, e[16:0]);
      else chk({16'h0, reg_err_out}, 17'h0);
    end
  end
  // cuts a hang short
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial
  begin
    int v;
    logic [15:0] x;
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rd(rtd_pkg::A_FIRST_RD, 17'h1);
    rd(rtd_pkg::A_FIRST_RD, 17'h0);
    rd(16'h0002, 17'h10000);
    rd(rtd_pkg::A_ALM_CLR, 17'h10000);
    wr(rtd_pkg::A_FORMAT, 16'h0001);
    rd(rtd_pkg::A_FORMAT, 17'h1);
    // each code's span ends
    for (int i = 0; i < 15; i++)
    begin
      wr(rtd_pkg::A_TYPE, {8'h00, codes[i]});
      rd(rtd_pkg::A_TYPE, {9'h000, codes[i]});
      for (int k = 0; k < 4; k++)
      begin
        v = k < 2 ? lo[i] - 1 + k : hi[i] - 2 + k;
        smp(v);
        x = v < lo[i] ? 16'h8000 : v > hi[i] ? 16'h7FFF : v[15:0];
        rd(rtd_pkg::A_ANALOG, {1'b0, x});
      end
    end
    foreach (codes[i]) wr(rtd_pkg::A_TYPE, 16'h002B + 16'(i % 3));
    rd(rtd_pkg::A_TYPE, 17'h81);
    // alarm
    wr(rtd_pkg::A_ALM_LO, 16'hFF9C);
    wr(rtd_pkg::A_ALM_HI, 16'h0064);
    rd(rtd_pkg::A_ALM_HI, 17'h64);
    wr(rtd_pkg::A_ALM_LATCH, 16'h0000);
    wr(rtd_pkg::A_ALM_EN, 16'h0001);
    smp(200);
    chk(alarm_out, 1'b1);
    smp(-200);
    chk(alarm_out, 1'b1);
    smp(0);
    chk(alarm_out, 1'b0);
    wr(rtd_pkg::A_ALM_LATCH, 16'h0001);
    smp(200);
    smp(0);
    chk(alarm_out, 1'b1);
    wr(rtd_pkg::A_ALM_CLR, 16'h0001);
    @(negedge clk_in);
    chk(alarm_out, 1'b0);
    // hex and resistance
    wr(rtd_pkg::A_FORMAT, 16'h0000);
    smp(99999);
    rd(rtd_pkg::A_ANALOG, {1'b0, meas_hex_in});
    rd(rtd_pkg::A_RES_LO, {1'b0, resistance_in[15:0]});
    rd(rtd_pkg::A_RES_HI, {1'b0, resistance_in[31:16]});
    // watchdog
    wr(rtd_pkg::A_DO_STATE, 16'h0000);
    wr(rtd_pkg::A_DO_SAFE, 16'h0001);
    wr(rtd_pkg::A_WD_VALUE, 16'h0003);
    wr(rtd_pkg::A_WD_VALUE, 16'h0100);
    rd(rtd_pkg::A_WD_VALUE, 17'h3);
    wr(rtd_pkg::A_WD_MODE, 16'h0000);
    wr(rtd_pkg::A_WD_EN, 16'h0001);
    for (int m = 0; m < 3; m++)
    begin
      wr(rtd_pkg::A_WD_FLAG, 16'h0001);
      if (m == 1) wr(rtd_pkg::A_WD_MODE, 16'h0001);
      if (m == 2) wr(rtd_pkg::A_WD_EN, 16'h0000);
      cmd();
      repeat (14) @(negedge clk_in);
      chk(wd_timeout_out, 1'b0);
      repeat (15) @(negedge clk_in);
      chk(wd_timeout_out, m < 2);
      chk(digital_output_out, m < 2);
      pulse_out_cmd();
      chk(wd_timeout_out, m == 0);
    end
    rd(rtd_pkg::A_WD_COUNT, 17'h2);
    wr(rtd_pkg::A_WD_COUNT, 16'h0005);
    rd(rtd_pkg::A_WD_COUNT, 17'h2);
    wr(rtd_pkg::A_WD_COUNT, 16'h0000);
    rd(rtd_pkg::A_WD_COUNT, 17'h0);
    // counter
    wr(rtd_pkg::A_CNT_CLR, 16'h0001);
    repeat (3)
    begin
      @(negedge clk_in) digital_input_line_in = 1'b1;
      @(negedge clk_in) digital_input_line_in = 1'b0;
    end
    @(negedge clk_in);
    rd(rtd_pkg::A_COUNTER, 17'h3);
    wr(rtd_pkg::A_CNT_CLR, 16'h0001);
    rd(rtd_pkg::A_COUNTER, 17'h0);
    // coils
    for (int b = 1; b >= 0; b--)
    begin
      wr(rtd_pkg::A_PROTOCOL, 16'(b));
      chk(protocol_rtu_out, b[0]);
      wr(rtd_pkg::A_FILTER, 16'(b));
      chk(filter_50hz_out, b[0]);
    end
    // display
    wr(rtd_pkg::A_DISPLAY_CONTROL_MODE, 16'h0002);
    wr(rtd_pkg::A_DISPLAY_HOST_VALUE, 16'h4E1F);
    wr(rtd_pkg::A_DISPLAY_HOST_VALUE, 16'h4E20);
    chk(display_indicator_out, 17'h4E1F);
    wr(rtd_pkg::A_DISPLAY_HOST_VALUE, 16'hB1E1);
    wr(rtd_pkg::A_DISPLAY_CONTROL_MODE, 16'h0003);
    chk({display_host_out, display_indicator_out}, 17'h1B1E1);
    // recovery reset
    @(negedge clk_in) reset_in = 1'b1;
    recovery_in = 1'b1;
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({recovery_out, comm_addr_out, comm_speed_out}, 17'h10006);
    rd(rtd_pkg::A_NODE, 17'h1);
    repeat (2) @(negedge clk_in);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [src/rtd_pkg.sv]
package rtd_pkg;
  // clock and watchdog time base
  localparam int CLK_HZ = 20000000;
  localparam int WD_UNIT_MS = 100;
  localparam int WD_TICK_CYCLES = CLK_HZ / 1000 * WD_UNIT_MS;
  localparam int WD_TICK_W = 22;
  // coil addresses
  localparam logic [15:0] A_DO_STATE = 16'h0021, A_DO_SAFE = 16'h0061,
    A_DO_PWRON = 16'h00C1, A_PROTOCOL = 16'h0101, A_FILTER = 16'h0103,
    A_WD_MODE = 16'h0104, A_WD_EN = 16'h0105, A_ALM_EN = 16'h0106,
    A_ALM_LATCH = 16'h0107, A_ALM_CLR = 16'h0108, A_CNT_CLR = 16'h010A,
    A_FORMAT = 16'h010D, A_WD_FLAG = 16'h010E, A_FIRST_RD = 16'h0111,
    A_DIN0 = 16'h2711;
  // input and holding register addresses
  localparam logic [15:0] A_ANALOG = 16'h7531, A_COUNTER = 16'h7591,
    A_RES_LO = 16'h7891, A_RES_HI = 16'h7892, A_ALM_LO = 16'h9D21,
    A_ALM_HI = 16'h9D22, A_FW_LO = 16'h9E21, A_FW_HI = 16'h9E22,
    A_NAME_LO = 16'h9E23, A_NAME_HI = 16'h9E24, A_NODE = 16'h9E25,
    A_SPEED = 16'h9E26, A_TYPE = 16'h9E27, A_DELAY = 16'h9E28,
    A_WD_VALUE = 16'h9E29, A_WD_COUNT = 16'h9E2C, A_DISPLAY_CONTROL_MODE = 16'h9E2F,
    A_DISPLAY_HOST_VALUE = 16'h9E30;
  // reset values
  localparam logic [15:0] NODE_RESET = 16'h0001, SPEED_RESET = 16'h0006,
    DISPLAY_CONTROL_MODE_MODULE = 16'h0001, DISPLAY_CONTROL_MODE_HOST = 16'h0002;
  localparam logic [7:0] TYPE_RESET = 8'h20;
  // recovery mode link settings
  localparam logic [7:0] RECOVERY_ADDR = 8'h00, RECOVERY_SPEED = 8'h06;
  // arbitrary identity values
  localparam logic [15:0] FW_LO_VAL = 16'h0001, FW_HI_VAL = 16'h0000,
    NAME_LO_VAL = 16'h1234, NAME_HI_VAL = 16'h0000;
  // range codes and display limits
  localparam logic [15:0] ENG_UNDER = 16'h8000, ENG_OVER = 16'h7FFF;
  localparam logic signed [15:0] DISP_MIN = -16'sd19999;
  localparam logic signed [15:0] DISP_MAX = 16'sd19999;
  localparam logic [7:0] WD_VALUE_MAX = 8'hFF;
  // power indicator states
  typedef enum logic [0:0] {
    RTD_LED_ON = 1'b0,
    RTD_LED_BUSY = 1'b1
  } rtd_pwr_state_t;
endpackage

// [src/rtd_regmap.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - range clamp codes
// - format coil
// - pt100 0.00385 scales
// - pt100 0.003916 scales
// - code 2A span
// - copper code spans
// - single channel code set
// - timeout value bound
// - timeout count, zero clears
// - timeout status, one clears
// - output writes may clear
// - watchdog enable coil
// - alarm enable, latch, clear
// - alarm limits
// - input edge counter
// - first read flag
// - protocol coil
// - filter coil
// - resistance word pair
// - display owner and value
// - power indicator during command
// - recovery link settings
// - timeout forces safe outputs
module rtd_regmap #(
  parameter int TICK_CYCLES = rtd_pkg::WD_TICK_CYCLES,
  parameter bit SINGLE_CHANNEL = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register access from the protocol engine
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic reg_err_out,
  // host traffic events
  input wire logic host_cmd_in,
  input wire logic host_resp_sent_in,
  input wire logic output_write_cmd_in,
  // measurement
  input wire logic sample_valid_in,
  input wire logic signed [31:0] meas_eng_in,
  input wire logic [15:0] meas_hex_in,
  input wire logic [31:0] resistance_in,
  // straps and pins
  input wire logic recovery_in,
  input wire logic digital_input_line_in,
  // configuration outputs
  output logic protocol_rtu_out,
  output logic filter_50hz_out,
  output logic [7:0] comm_addr_out,
  output logic [7:0] comm_speed_out,
  output logic recovery_out,
  output logic [15:0] reply_delay_out,
  // control outputs
  output logic digital_output_out,
  output logic alarm_out,
  output logic wd_timeout_out,
  output logic power_indicator_out,
  output logic display_host_out,
  output logic [15:0] display_indicator_out
);
  rtd_scale_if sc_if ();
  rtd_pkg::rtd_pwr_state_t pwr_q;
  logic do_state_q, do_safe_q, do_pwron_q, init_q;
  logic protocol_q, filter_q, wd_mode_q, wd_en_q;
  logic alm_en_q, alm_latch_q, alarm_q, format_q;
  logic wd_flag_q, first_q, recovery_q, din_prev_q;
  logic [15:0] node_q, speed_q, delay_q, display_control_mode_q;
  logic [15:0] display_host_value_q, analog_q, counter_q, wd_count_q;
  logic signed [15:0] alm_lo_q, alm_hi_q;
  logic [7:0] type_q, wd_value_q, tenths_q;
  logic [31:0] res_q;
  logic [rtd_pkg::WD_TICK_W-1:0] tick_q;
  logic wd_armed_q, wd_fire, tick_end;
  logic [15:0] eng16, rdata_d;
  logic rd_hit, alm_cond;

  // write strobe for one address
  function automatic logic wr_at(input logic [15:0] a);
    wr_at = reg_wr_in && (reg_addr_in == a);
  endfunction

  rtd_scale #(
    .SINGLE_CHANNEL(SINGLE_CHANNEL)
  ) u_scale (
    .sc(sc_if.lookup)
  );

  // lookup checks a code being written
  assign sc_if.type_code = wr_at(rtd_pkg::A_TYPE) ?
    reg_wdata_in[7:0] : type_q;

  // strap taken after release
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      init_q <= 1'b1;
      recovery_q <= 1'b0;
    end
    else if (init_q)
    begin
      init_q <= 1'b0;
      recovery_q <= recovery_in;
    end
  end

  // single-bit configuration coils
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      protocol_q <= 1'b0;
      filter_q <= 1'b0;
      wd_mode_q <= 1'b0;
      wd_en_q <= 1'b0;
      alm_en_q <= 1'b0;
      alm_latch_q <= 1'b0;
      format_q <= 1'b0;
      do_safe_q <= 1'b0;
      do_pwron_q <= 1'b0;
    end
    else
    begin
      if (wr_at(rtd_pkg::A_PROTOCOL))
        protocol_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_FILTER))
        filter_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_WD_MODE))
        wd_mode_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_WD_EN))
        wd_en_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_ALM_EN))
        alm_en_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_ALM_LATCH))
        alm_latch_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_FORMAT))
        format_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_DO_SAFE))
        do_safe_q <= reg_wdata_in[0];
      if (wr_at(rtd_pkg::A_DO_PWRON))
        do_pwron_q <= reg_wdata_in[0];
    end
  end

  // digital output, loaded with its power-on value
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      do_state_q <= 1'b0;
    else if (init_q)
      do_state_q <= do_pwron_q;
    else if (wr_at(rtd_pkg::A_DO_STATE))
      do_state_q <= reg_wdata_in[0];
  end

  // word configuration registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      node_q <= rtd_pkg::NODE_RESET;
      speed_q <= rtd_pkg::SPEED_RESET;
      type_q <= rtd_pkg::TYPE_RESET;
      delay_q <= '0;
      wd_value_q <= '0;
      alm_lo_q <= '0;
      alm_hi_q <= '0;
      display_control_mode_q <= rtd_pkg::DISPLAY_CONTROL_MODE_MODULE;
      display_host_value_q <= '0;
    end
    else
    begin
      if (wr_at(rtd_pkg::A_NODE))
        node_q <= reg_wdata_in;
      if (wr_at(rtd_pkg::A_SPEED))
        speed_q <= reg_wdata_in;
      if (wr_at(rtd_pkg::A_TYPE) && sc_if.supported)
        type_q <= reg_wdata_in[7:0];
      if (wr_at(rtd_pkg::A_DELAY))
        delay_q <= reg_wdata_in;
      if (wr_at(rtd_pkg::A_WD_VALUE) &&
          reg_wdata_in <= {8'h00, rtd_pkg::WD_VALUE_MAX})
        wd_value_q <= reg_wdata_in[7:0];
      if (wr_at(rtd_pkg::A_ALM_LO))
        alm_lo_q <= reg_wdata_in;
      if (wr_at(rtd_pkg::A_ALM_HI))
        alm_hi_q <= reg_wdata_in;
      if (wr_at(rtd_pkg::A_DISPLAY_CONTROL_MODE) &&
          (reg_wdata_in == rtd_pkg::DISPLAY_CONTROL_MODE_MODULE ||
           reg_wdata_in == rtd_pkg::DISPLAY_CONTROL_MODE_HOST))
        display_control_mode_q <= reg_wdata_in;
      if (wr_at(rtd_pkg::A_DISPLAY_HOST_VALUE) &&
          $signed(reg_wdata_in) >= rtd_pkg::DISP_MIN &&
          $signed(reg_wdata_in) <= rtd_pkg::DISP_MAX)
        display_host_value_q <= reg_wdata_in;
    end
  end

  // engineering value clamped to the range codes
  always_comb
  begin
    if (meas_eng_in < sc_if.fs_min)
      eng16 = rtd_pkg::ENG_UNDER;
    else if (meas_eng_in > sc_if.fs_max)
      eng16 = rtd_pkg::ENG_OVER;
    else
      eng16 = meas_eng_in[15:0];
  end

  // alarm condition against the limits
  assign alm_cond = alm_en_q && ($signed(eng16) < alm_lo_q ||
    $signed(eng16) > alm_hi_q);

  // analog and resistance registers follow each sample
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      analog_q <= '0;
      res_q <= '0;
    end
    else if (sample_valid_in)
    begin
      analog_q <= format_q ? eng16 : meas_hex_in;
      res_q <= resistance_in;
    end
  end

  // alarm: momentary follows, latched holds until cleared
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      alarm_q <= 1'b0;
    else if (!alm_en_q)
      alarm_q <= 1'b0;
    else if (sample_valid_in && alm_cond)
      alarm_q <= 1'b1;
    else if (sample_valid_in && !alm_latch_q)
      alarm_q <= 1'b0;
    else if (wr_at(rtd_pkg::A_ALM_CLR) && reg_wdata_in[0])
      alarm_q <= 1'b0;
  end

  // rising edges on the input line, set wins over clear
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      din_prev_q <= 1'b0;
      counter_q <= '0;
    end
    else
    begin
      din_prev_q <= digital_input_line_in;
      if (digital_input_line_in && !din_prev_q)
      begin
        if (wr_at(rtd_pkg::A_CNT_CLR) && reg_wdata_in[0])
          counter_q <= 16'h0001;
        else
          counter_q <= counter_q + 16'h0001;
      end
      else if (wr_at(rtd_pkg::A_CNT_CLR) && reg_wdata_in[0])
        counter_q <= '0;
    end
  end

  // watchdog tick of one tenth of a second
  assign tick_end = (tick_q == rtd_pkg::WD_TICK_W'(TICK_CYCLES - 1));
  assign wd_fire = wd_en_q && wd_armed_q && (wd_value_q != 8'h00) &&
    !host_cmd_in && tick_end && (tenths_q == wd_value_q - 8'h01);

  // interval timer restarted by each host command
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      tick_q <= '0;
      tenths_q <= '0;
      wd_armed_q <= 1'b0;
    end
    else if (host_cmd_in || !wd_en_q)
    begin
      tick_q <= '0;
      tenths_q <= '0;
      wd_armed_q <= host_cmd_in;
    end
    else if (wd_fire)
    begin
      tick_q <= '0;
      tenths_q <= '0;
      wd_armed_q <= 1'b0;
    end
    else if (tick_end)
    begin
      tick_q <= '0;
      tenths_q <= tenths_q + 8'h01;
    end
    else
      tick_q <= tick_q + rtd_pkg::WD_TICK_W'(1);
  end

  // timeout status, a new timeout wins over any clear
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      wd_flag_q <= 1'b0;
    else if (wd_fire)
      wd_flag_q <= 1'b1;
    else if (wr_at(rtd_pkg::A_WD_FLAG) && reg_wdata_in[0])
      wd_flag_q <= 1'b0;
    else if (wd_mode_q && (output_write_cmd_in ||
             wr_at(rtd_pkg::A_DO_STATE)))
      wd_flag_q <= 1'b0;
  end

  // timeout count, increment wins over a zero write
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      wd_count_q <= '0;
    else if (wd_fire)
    begin
      if (wr_at(rtd_pkg::A_WD_COUNT) && reg_wdata_in == 16'h0000)
        wd_count_q <= 16'h0001;
      else
        wd_count_q <= wd_count_q + 16'h0001;
    end
    else if (wr_at(rtd_pkg::A_WD_COUNT) && reg_wdata_in == 16'h0000)
      wd_count_q <= '0;
  end

  // power indicator dark between command and response
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      pwr_q <= rtd_pkg::RTD_LED_ON;
    else
      case (pwr_q)
        rtd_pkg::RTD_LED_ON:
          if (host_cmd_in)
            pwr_q <= rtd_pkg::RTD_LED_BUSY;
        rtd_pkg::RTD_LED_BUSY:
          if (host_resp_sent_in)
            pwr_q <= rtd_pkg::RTD_LED_ON;
        default: pwr_q <= rtd_pkg::RTD_LED_ON;
      endcase
  end

  // first-read flag drops after it has been read once
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      first_q <= 1'b1;
    else if (reg_rd_in && reg_addr_in == rtd_pkg::A_FIRST_RD)
      first_q <= 1'b0;
  end

  // read decode
  always_comb
  begin
    rdata_d = '0;
    rd_hit = 1'b1;
    if (reg_addr_in == rtd_pkg::A_DO_STATE)
      rdata_d[0] = do_state_q;
    else if (reg_addr_in == rtd_pkg::A_DO_SAFE)
      rdata_d[0] = do_safe_q;
    else if (reg_addr_in == rtd_pkg::A_DO_PWRON)
      rdata_d[0] = do_pwron_q;
    else if (reg_addr_in == rtd_pkg::A_PROTOCOL)
      rdata_d[0] = protocol_q;
    else if (reg_addr_in == rtd_pkg::A_FILTER)
      rdata_d[0] = filter_q;
    else if (reg_addr_in == rtd_pkg::A_WD_MODE)
      rdata_d[0] = wd_mode_q;
    else if (reg_addr_in == rtd_pkg::A_WD_EN)
      rdata_d[0] = wd_en_q;
    else if (reg_addr_in == rtd_pkg::A_ALM_EN)
      rdata_d[0] = alm_en_q;
    else if (reg_addr_in == rtd_pkg::A_ALM_LATCH)
      rdata_d[0] = alm_latch_q;
    else if (reg_addr_in == rtd_pkg::A_FORMAT)
      rdata_d[0] = format_q;
    else if (reg_addr_in == rtd_pkg::A_WD_FLAG)
      rdata_d[0] = wd_flag_q;
    else if (reg_addr_in == rtd_pkg::A_FIRST_RD)
      rdata_d[0] = first_q;
    else if (reg_addr_in == rtd_pkg::A_DIN0)
      rdata_d[0] = din_prev_q;
    else if (reg_addr_in == rtd_pkg::A_ANALOG)
      rdata_d = analog_q;
    else if (reg_addr_in == rtd_pkg::A_COUNTER)
      rdata_d = counter_q;
    else if (reg_addr_in == rtd_pkg::A_RES_LO)
      rdata_d = res_q[15:0];
    else if (reg_addr_in == rtd_pkg::A_RES_HI)
      rdata_d = res_q[31:16];
    else if (reg_addr_in == rtd_pkg::A_ALM_LO)
      rdata_d = alm_lo_q;
    else if (reg_addr_in == rtd_pkg::A_ALM_HI)
      rdata_d = alm_hi_q;
    else if (reg_addr_in == rtd_pkg::A_FW_LO)
      rdata_d = rtd_pkg::FW_LO_VAL;
    else if (reg_addr_in == rtd_pkg::A_FW_HI)
      rdata_d = rtd_pkg::FW_HI_VAL;
    else if (reg_addr_in == rtd_pkg::A_NAME_LO)
      rdata_d = rtd_pkg::NAME_LO_VAL;
    else if (reg_addr_in == rtd_pkg::A_NAME_HI)
      rdata_d = rtd_pkg::NAME_HI_VAL;
    else if (reg_addr_in == rtd_pkg::A_NODE)
      rdata_d = node_q;
    else if (reg_addr_in == rtd_pkg::A_SPEED)
      rdata_d = speed_q;
    else if (reg_addr_in == rtd_pkg::A_TYPE)
      rdata_d = {8'h00, type_q};
    else if (reg_addr_in == rtd_pkg::A_DELAY)
      rdata_d = delay_q;
    else if (reg_addr_in == rtd_pkg::A_WD_VALUE)
      rdata_d = {8'h00, wd_value_q};
    else if (reg_addr_in == rtd_pkg::A_WD_COUNT)
      rdata_d = wd_count_q;
    else if (reg_addr_in == rtd_pkg::A_DISPLAY_CONTROL_MODE)
      rdata_d = display_control_mode_q;
    else
      rd_hit = 1'b0;
  end

  // answer one cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out <= '0;
      reg_ack_out <= 1'b0;
      reg_err_out <= 1'b0;
    end
    else
    begin
      reg_ack_out <= reg_rd_in || reg_wr_in;
      reg_err_out <= reg_rd_in && !rd_hit;
      if (reg_rd_in)
        reg_rdata_out <= rd_hit ? rdata_d : '0;
    end
  end

  // link settings, overridden in recovery mode
  assign recovery_out = recovery_q;
  assign protocol_rtu_out = protocol_q && !recovery_q;
  assign comm_addr_out = recovery_q ? rtd_pkg::RECOVERY_ADDR :
    node_q[7:0];
  assign comm_speed_out = recovery_q ? rtd_pkg::RECOVERY_SPEED :
    speed_q[7:0];
  assign filter_50hz_out = filter_q;
  assign reply_delay_out = delay_q;
  // outputs and indicators
  assign wd_timeout_out = wd_flag_q;
  assign digital_output_out = wd_flag_q ? do_safe_q : do_state_q;
  assign alarm_out = alarm_q;
  assign power_indicator_out = (pwr_q == rtd_pkg::RTD_LED_ON);
  assign display_host_out = (display_control_mode_q == rtd_pkg::DISPLAY_CONTROL_MODE_HOST);
  assign display_indicator_out = display_host_out ? display_host_value_q :
    analog_q;
endmodule
`default_nettype wire

// [src/rtd_scale.sv]
`timescale 1ns/1ps
`default_nettype none
module rtd_scale #(
  parameter bit SINGLE_CHANNEL = 1'b1
) (
  // lookup port
  rtd_scale_if.lookup sc
);
  // full-scale table per sensor type code
  always_comb
  begin
    sc.fs_min = 32'sd0;
    sc.fs_max = 32'sd0;
    sc.supported = 1'b1;
    case (sc.type_code)
      8'h20, 8'h24:
      begin
        sc.fs_min = -32'sd10000;
        sc.fs_max = 32'sd10000;
      end
      8'h21, 8'h25: sc.fs_max = 32'sd10000;
      8'h22, 8'h26: sc.fs_max = 32'sd20000;
      8'h23, 8'h27: sc.fs_max = 32'sd6000;
      8'h28:
      begin
        sc.fs_min = -32'sd8000;
        sc.fs_max = 32'sd10000;
      end
      8'h29: sc.fs_max = 32'sd10000;
      8'h2A, 8'h80, 8'h81:
      begin
        sc.fs_min = -32'sd2000;
        sc.fs_max = 32'sd6000;
      end
      8'h2B:
      begin
        sc.fs_min = -32'sd2000;
        sc.fs_max = 32'sd15000;
        sc.supported = !SINGLE_CHANNEL;
      end
      8'h2C:
      begin
        sc.fs_max = 32'sd20000;
        sc.supported = !SINGLE_CHANNEL;
      end
      8'h2E, 8'h2F:
      begin
        sc.fs_min = -32'sd20000;
        sc.fs_max = 32'sd20000;
      end
      default: sc.supported = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [src/rtd_scale_if.sv]
`timescale 1ns/1ps
`default_nettype none
// type code in, full-scale pair and support flag out
interface rtd_scale_if;
  logic [7:0] type_code;
  logic signed [31:0] fs_min;
  logic signed [31:0] fs_max;
  logic supported;
  modport lookup (input type_code, output fs_min, fs_max, supported);
  modport user (output type_code, input fs_min, fs_max, supported);
endinterface
`default_nettype wire
